// ---- haptic_level_pkg.sv ----
// haptic_level_pkg: register map, reset values, field sizes and states
// for the haptic drive level parameter bank; shared by both design files.
package haptic_level_pkg;

    localparam logic [7:0] ADDR_BRAKE_TIME_ADJUST = 8'h10;
    localparam logic [7:0] ADDR_NOMINAL_MOTOR_LEVEL = 8'h16;
    localparam logic [7:0] ADDR_OVERDRIVE_CEILING = 8'h17;
    localparam logic [7:0] ADDR_CALIB_LOSS_COMP = 8'h18;

    localparam logic [7:0] RST_BRAKE_TIME_ADJUST = 8'h00;
    localparam logic [7:0] RST_NOMINAL_MOTOR_LEVEL = 8'h3f;
    localparam logic [7:0] RST_OVERDRIVE_CEILING = 8'h89;
    localparam logic [7:0] RST_CALIB_LOSS_COMP = 8'h0d;

    // one offset unit and one waveform time unit are both this long
    localparam int BRAKE_STEP_MS = 5;

    // waveform memory: one entry is {signed level, duration in steps}
    localparam int WAVE_AW = 4;
    localparam int WAVE_DW = 16;
    localparam logic [4:0] WAVE_DEPTH = 5'h10;

    // gain: level * ref * (COMP_BASE + comp) / (SAMPLE_FULL * COMP_BASE)
    localparam logic [8:0] COMP_BASE = 9'h0ff;
    localparam logic [24:0] GAIN_DIV = 25'h0007e81; // 127 * 255
    localparam logic signed [7:0] SAMPLE_MAX = 8'sh7f;
    localparam logic [7:0] OUT_MAX = 8'hff;

    // gray codes along idle -> scan -> play, calibration off idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_PLAY = 2'b11,
        ST_CAL = 2'b10
    } fsm_type;

endpackage : haptic_level_pkg

// ---- haptic_wave_mem.sv ----
// haptic_wave_mem: small waveform store, one write port and one read port.
// assumes the caller never reads an entry in the cycle it is written.
`timescale 1ns/1ps
module haptic_wave_mem
    import haptic_level_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [WAVE_AW-1:0] wr_addr_i,
    input wire logic [WAVE_DW-1:0] wr_data_i,
    input wire logic [WAVE_AW-1:0] rd_addr_i,
    output logic [WAVE_DW-1:0] rd_data_o
);
    logic [WAVE_DW-1:0] mem [0:(1<<WAVE_AW)-1];

    // registered read: data appear one edge after the address
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : haptic_wave_mem

// ---- haptic_drive_level_params.sv ----
// haptic_drive_level_params: level parameter registers and the small
// playback and calibration engine that reads them.
// assumes the register port is fed by the serial bus engine on clk_sys_i,
// and that waveform, mode and measurement inputs come from same-clock logic.
`timescale 1ns/1ps

// Behaviour
// - brake segment length moved by brake offset
// - brake segment is most negative sample
// - offset only in open loop
// - offset signed, one unit per 5 ms
// - closed loop references nominal level, reset 0x3f
// - open loop ignores nominal level
// - closed loop output clamped to ceiling 0x89
// - open loop full scale is ceiling
// - calibration stores compensation, reset 0x0d
// - gain times one plus comp over 255
// - calibration derives comp from impedance
// - trigger in calibration mode starts calibration
module haptic_drive_level_params
    import haptic_level_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic closed_loop_i,
    input wire logic go_i,
    input wire logic mode_cal_i,
    input wire logic [7:0] impedance_i,
    input wire logic impedance_valid_i,
    input wire logic wave_wr_i,
    input wire logic [7:0] wave_level_i,
    input wire logic [7:0] wave_time_i,
    input wire logic wave_end_i,
    output logic [7:0] drive_level_o,
    output logic [7:0] drive_time_o,
    output logic drive_valid_o,
    output logic drive_brake_o,
    output logic cal_done_o,
    output logic busy_o
);
    typedef struct packed {
        fsm_type fsm;
        logic [7:0] brake_time_adjust;
        logic [7:0] nominal_motor_level;
        logic [7:0] overdrive_ceiling;
        logic [7:0] calib_loss_compensation;
        logic [7:0] rdata;
        logic [4:0] count;
        logic [4:0] rd_ptr;
        logic rd_vld;
        logic [WAVE_AW-1:0] cur_idx;
        logic signed [7:0] min_val;
        logic [WAVE_AW-1:0] min_idx;
        logic [7:0] drive_level;
        logic [7:0] drive_time;
        logic drive_valid;
        logic drive_brake;
        logic cal_done;
        logic busy;
    } state_type;

    state_type st;
    state_type next_st;
    logic [WAVE_DW-1:0] mem_rdata;
    logic mem_wr;
    logic signed [7:0] smp_level;
    logic [7:0] smp_time;
    logic [7:0] mag;
    logic [7:0] ref_level;
    logic [24:0] product;
    logic [24:0] scaled;
    logic [7:0] level;
    logic signed [9:0] adj_time;
    logic is_brake;
    logic [7:0] out_time;

    // entries are only accepted while idle, so writes never meet a read
    assign mem_wr = wave_wr_i && (st.fsm == ST_IDLE) && (st.count < WAVE_DEPTH);

    haptic_wave_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(st.count[WAVE_AW-1:0]),
        .wr_data_i({wave_level_i, wave_time_i}),
        .rd_addr_i(st.rd_ptr[WAVE_AW-1:0]),
        .rd_data_o(mem_rdata)
    );

    // level path: magnitude scaled by the active reference and compensation
    always_comb begin
        smp_level = mem_rdata[15:8];
        smp_time = mem_rdata[7:0];
        mag = smp_level[7] ? 8'(-smp_level) : 8'(smp_level);
        ref_level = closed_loop_i ? st.nominal_motor_level : st.overdrive_ceiling;
        product = 25'(mag) * 25'(ref_level) * 25'(COMP_BASE + 9'(st.calib_loss_compensation));
        scaled = product / GAIN_DIV;
        level = (scaled > 25'(OUT_MAX)) ? OUT_MAX : scaled[7:0];
        // in closed loop, overdrive and braking may exceed nominal but never the ceiling
        if (closed_loop_i && (level > st.overdrive_ceiling)) begin
            level = st.overdrive_ceiling;
        end
        is_brake = (st.cur_idx == st.min_idx) && smp_level[7];
        // both terms count in the same 5 ms step, so a plain signed add works
        adj_time = $signed({2'b00, smp_time}) + 10'($signed(st.brake_time_adjust));
        if (adj_time < 10'sd0) begin
            out_time = 8'h00;
        end else if (adj_time > 10'sd255) begin
            out_time = OUT_MAX;
        end else begin
            out_time = adj_time[7:0];
        end
        if (!(is_brake && !closed_loop_i)) begin
            out_time = smp_time;
        end
    end

    // next state: register port, load, scan, play and calibration
    always_comb begin
        next_st = st;
        next_st.drive_valid = 1'b0;
        next_st.cal_done = 1'b0;
        next_st.rd_vld = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_BRAKE_TIME_ADJUST: next_st.brake_time_adjust = reg_wdata_i;
                ADDR_NOMINAL_MOTOR_LEVEL: next_st.nominal_motor_level = reg_wdata_i;
                ADDR_OVERDRIVE_CEILING: next_st.overdrive_ceiling = reg_wdata_i;
                ADDR_CALIB_LOSS_COMP: next_st.calib_loss_compensation = reg_wdata_i;
                default: next_st.rdata = st.rdata;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_BRAKE_TIME_ADJUST: next_st.rdata = st.brake_time_adjust;
                ADDR_NOMINAL_MOTOR_LEVEL: next_st.rdata = st.nominal_motor_level;
                ADDR_OVERDRIVE_CEILING: next_st.rdata = st.overdrive_ceiling;
                ADDR_CALIB_LOSS_COMP: next_st.rdata = st.calib_loss_compensation;
                default: next_st.rdata = 8'h00;
            endcase
        end
        case (st.fsm)
            ST_IDLE: begin
                if (mem_wr) begin
                    next_st.count = st.count + 5'h01;
                end
                if (go_i && mode_cal_i) begin
                    next_st.fsm = ST_CAL;
                end else if (wave_end_i && (st.count != 5'h00)) begin
                    next_st.fsm = ST_SCAN;
                    next_st.rd_ptr = 5'h00;
                    next_st.min_val = SAMPLE_MAX;
                    next_st.min_idx = '0;
                end
            end
            ST_SCAN: begin
                // first strictly lowest entry wins a tie
                if (st.rd_vld && (smp_level < st.min_val)) begin
                    next_st.min_val = smp_level;
                    next_st.min_idx = st.cur_idx;
                end
                if (st.rd_ptr < st.count) begin
                    next_st.rd_ptr = st.rd_ptr + 5'h01;
                    next_st.rd_vld = 1'b1;
                    next_st.cur_idx = st.rd_ptr[WAVE_AW-1:0];
                end else if (!st.rd_vld) begin
                    next_st.fsm = ST_PLAY;
                    next_st.rd_ptr = 5'h00;
                end
            end
            ST_PLAY: begin
                if (st.rd_vld) begin
                    next_st.drive_valid = 1'b1;
                    next_st.drive_level = level;
                    next_st.drive_time = out_time;
                    next_st.drive_brake = is_brake;
                end
                if (st.rd_ptr < st.count) begin
                    next_st.rd_ptr = st.rd_ptr + 5'h01;
                    next_st.rd_vld = 1'b1;
                    next_st.cur_idx = st.rd_ptr[WAVE_AW-1:0];
                end else if (!st.rd_vld) begin
                    next_st.fsm = ST_IDLE;
                    next_st.count = 5'h00;
                end
            end
            ST_CAL: begin
                // measured impedance code maps to the loss term; beats a host write
                if (impedance_valid_i) begin
                    next_st.calib_loss_compensation = impedance_i;
                    next_st.cal_done = 1'b1;
                    next_st.fsm = ST_IDLE;
                end
            end
            default: next_st.fsm = ST_IDLE;
        endcase
        next_st.busy = (next_st.fsm != ST_IDLE);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st <= '0;
            st.fsm <= ST_IDLE;
            st.brake_time_adjust <= RST_BRAKE_TIME_ADJUST;
            st.nominal_motor_level <= RST_NOMINAL_MOTOR_LEVEL;
            st.overdrive_ceiling <= RST_OVERDRIVE_CEILING;
            st.calib_loss_compensation <= RST_CALIB_LOSS_COMP;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign drive_level_o = st.drive_level;
    assign drive_time_o = st.drive_time;
    assign drive_valid_o = st.drive_valid;
    assign drive_brake_o = st.drive_brake;
    assign cal_done_o = st.cal_done;
    assign busy_o = st.busy;

    a_clamp_closed: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        drive_valid_o && $past(closed_loop_i) |-> drive_level_o <= $past(st.overdrive_ceiling))
        else $error("closed loop level above ceiling");
    a_cal_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_IDLE && go_i && mode_cal_i |=> st.fsm == ST_CAL && busy_o)
        else $error("calibration not started");
    a_cal_store: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_CAL && impedance_valid_i |=> cal_done_o
        && st.calib_loss_compensation == $past(impedance_i))
        else $error("compensation not stored");
    a_closed_no_adj: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY && st.rd_vld && closed_loop_i |=> drive_time_o == $past(smp_time))
        else $error("brake offset applied in closed loop");
    a_brake_sat: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY && st.rd_vld && is_brake && !closed_loop_i && adj_time < 0
        |=> drive_time_o == 8'h00)
        else $error("brake time not saturated at zero");
    a_brake_add: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY && st.rd_vld && is_brake && !closed_loop_i
        && adj_time >= 0 && adj_time <= 255 |=> drive_time_o == $past(adj_time[7:0]))
        else $error("brake time offset wrong");
    a_min_found: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_SCAN && st.rd_vld |=> st.min_val <= $past(smp_level))
        else $error("most negative entry missed");
    a_scale_ref: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY && st.rd_vld && !closed_loop_i && mag == 8'h00
        |=> drive_valid_o && drive_level_o == 8'h00)
        else $error("zero sample gave output");
    a_open_full: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY && st.rd_vld && !closed_loop_i && mag == 8'h7f
        |=> drive_valid_o && drive_level_o >= $past(st.overdrive_ceiling))
        else $error("open loop full scale below ceiling");
    a_play_done: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        st.fsm == ST_PLAY |-> ##[1:40] st.fsm == ST_IDLE)
        else $error("playback did not finish");
    c_cal: cover property (@(posedge clk_sys_i) cal_done_o);
    c_brake_open: cover property (@(posedge clk_sys_i)
        drive_valid_o && drive_brake_o && !closed_loop_i);
    c_clamp: cover property (@(posedge clk_sys_i)
        drive_valid_o && closed_loop_i && drive_level_o == st.overdrive_ceiling);
endmodule : haptic_drive_level_params

// ---- host_reg_model.sv ----
// host_reg_model: behavioural host that writes and reads the level bank.
// assumes single-byte transfers on the register port, all on clk_sys_i.
`timescale 1ns/1ps
module host_reg_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o
);
    // idle port at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // one-cycle write strobe; address and data are inverted on release
    // so that a design latching stale values is caught
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask : write_reg

    // read data is registered and holds, so it is taken one edge later
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        @(posedge clk_sys_i);
        data = reg_rdata_i;
    endtask : read_reg
endmodule : host_reg_model

// ---- haptic_drive_level_params_tb_top.sv ----
// haptic_drive_level_params_tb_top: self-checking bench for the level bank.
// assumes the host model drives the register port; engine inputs are driven here.
`timescale 1ns/1ps
module haptic_drive_level_params_tb_top;
    import haptic_level_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
    logic reg_wr_i, reg_rd_i, drive_valid_o, drive_brake_o, cal_done_o, busy_o;
    logic closed_loop_i = 1'b0, go_i = 1'b0, mode_cal_i = 1'b0;
    logic impedance_valid_i = 1'b0, wave_wr_i = 1'b0, wave_end_i = 1'b0;
    logic [7:0] impedance_i = 8'h00, wave_level_i = 8'h00, wave_time_i = 8'h00;
    logic [7:0] drive_level_o, drive_time_o;
    logic signed [7:0] lv [3];
    logic [7:0] tm [3];
    logic [7:0] nom, ceil_v, comp, brk;
    int bad_count = 0;
    int checks = 0;

    // 50 MHz system clock
    always #10 clk_sys_i = ~clk_sys_i;

    haptic_drive_level_params DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .closed_loop_i(closed_loop_i),
        .go_i(go_i), .mode_cal_i(mode_cal_i), .impedance_i(impedance_i),
        .impedance_valid_i(impedance_valid_i), .wave_wr_i(wave_wr_i),
        .wave_level_i(wave_level_i), .wave_time_i(wave_time_i), .wave_end_i(wave_end_i),
        .drive_level_o(drive_level_o), .drive_time_o(drive_time_o),
        .drive_valid_o(drive_valid_o), .drive_brake_o(drive_brake_o),
        .cal_done_o(cal_done_o), .busy_o(busy_o));

    host_reg_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .reg_rd_o(reg_rd_i));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error: %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // write through the host and keep a mirror for expectations
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a == ADDR_BRAKE_TIME_ADJUST) brk = d;
        if (a == ADDR_NOMINAL_MOTOR_LEVEL) nom = d;
        if (a == ADDR_OVERDRIVE_CEILING) ceil_v = d;
        if (a == ADDR_CALIB_LOSS_COMP) comp = d;
    endtask : wr

    // load three entries, play them and judge every driven entry
    task automatic play(input logic closed);
        int n, lim, bi, mn, v, t;
        n = 0;
        bi = -1;
        mn = 0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            closed_loop_i <= closed;
            wave_wr_i <= 1'b1;
            wave_level_i <= lv[k];
            wave_time_i <= tm[k];
            if (int'(lv[k]) < mn) begin
                mn = int'(lv[k]);
                bi = k;
            end
        end
        @(posedge clk_sys_i);
        wave_wr_i <= 1'b0;
        wave_end_i <= 1'b1;
        @(posedge clk_sys_i);
        wave_end_i <= 1'b0;
        for (lim = 0; lim < 200 && n < 3; lim++) begin
            @(negedge clk_sys_i);
            if (drive_valid_o === 1'b1) begin
                v = (lv[n] < 0) ? -int'(lv[n]) : int'(lv[n]);
                v = v * int'(closed ? nom : ceil_v) * (255 + int'(comp)) / (127 * 255);
                if (v > 255) v = 255;
                if (closed && v > int'(ceil_v)) v = int'(ceil_v);
                t = int'(tm[n]);
                if (!closed && n == bi) t = t + int'($signed(brk));
                if (t < 0) t = 0;
                if (t > 255) t = 255;
                chk("level", drive_level_o, 8'(v));
                chk("time", drive_time_o, 8'(t));
                chk("brake", {7'h00, drive_brake_o}, {7'h00, n == bi});
                n++;
            end
        end
        if (n < 3) begin
            bad_count++; // playback never drove all entries
            summarize();
        end else begin
            for (lim = 0; lim < 20 && busy_o !== 1'b0; lim++) @(negedge clk_sys_i);
            chk("busy", {7'h00, busy_o}, 8'h00);
            if (busy_o !== 1'b0) summarize();
            else $display("test play closed=%0b done", closed);
        end
    endtask : play

    task automatic t_regs();
        logic [7:0] a [5] = '{8'h10, 8'h16, 8'h17, 8'h18, 8'h11};
        logic [7:0] e [5] = '{8'h00, 8'h3f, 8'h89, 8'h0d, 8'h00};
        for (int k = 0; k < 5; k++) begin
            host.read_reg(a[k], rd);
            chk("reset value", rd, e[k]);
        end
        for (int k = 0; k < 5; k++) wr(a[k], 8'h5a + 8'(k));
        for (int k = 0; k < 5; k++) begin
            host.read_reg(a[k], rd);
            chk("readback", rd, (k == 4) ? 8'h00 : 8'h5a + 8'(k));
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_cal();
        int lim;
        wr(ADDR_NOMINAL_MOTOR_LEVEL, 8'h50);
        @(posedge clk_sys_i);
        mode_cal_i <= 1'b1;
        go_i <= 1'b1;
        @(posedge clk_sys_i);
        go_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        impedance_i <= 8'h40;
        impedance_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        impedance_valid_i <= 1'b0;
        for (lim = 0; lim < 10 && cal_done_o !== 1'b1; lim++) @(negedge clk_sys_i);
        chk("cal done", {7'h00, cal_done_o}, 8'h01);
        chk("cal busy", {7'h00, busy_o}, 8'h00);
        if (cal_done_o !== 1'b1) summarize();
        // inputs only move on the rising edge
        @(posedge clk_sys_i);
        mode_cal_i <= 1'b0;
        host.read_reg(ADDR_CALIB_LOSS_COMP, rd);
        chk("compensation", rd, 8'h40);
        comp = 8'h40;
        $display("test cal done");
    endtask : t_cal

    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_regs();
        lv = '{8'sh7f, -8'sd64, -8'sd100};
        tm = '{8'h0a, 8'h04, 8'h03};
        wr(ADDR_BRAKE_TIME_ADJUST, 8'h02);
        play(1'b0);
        wr(ADDR_NOMINAL_MOTOR_LEVEL, 8'hff);
        wr(ADDR_OVERDRIVE_CEILING, 8'h60);
        play(1'b1);
        wr(ADDR_BRAKE_TIME_ADJUST, 8'h80);
        play(1'b0);
        t_cal();
        lv[0] = 8'sh00; // a silent entry must drive level zero
        play(1'b0);
        summarize();
    end
endmodule : haptic_drive_level_params_tb_top
